// ---- common/lcd_instr_pkg.sv ----
// Constants for the character display instruction decoder.
// Assumes a 200 MHz core clock; bus pins are synchronised by the decoder.
// Overview of operation
// - Code 0001xxxx is cursor or display shift
// - Shift select bits choose cursor or display, direction
// - Two-line cursor wraps from line one to two
// - Display shift leaves pointer, moves shared offset
// - Code 001xxxxx is function set, bit4 bus width
// - Four-bit mode assembles two nibbles per byte
// - Bit3 selects line count, bit2 font height
// - Code 01xxxxxx loads glyph address, selects glyph RAM
// - Top bit set loads character address, selects char RAM
// - Character addresses loaded as given, not limited per line mode
// - Status read returns busy flag and pointer
// - Data write stores byte, steps pointer
// - Address load prefetches RAM into output register
// - Cursor shift reloads output register for char reads
// - Data read steps pointer and prefetches next
// - Clear fills char RAM with spaces, pointer zero
// - Return home zeroes pointer and display offset
// - Short instructions busy 39us, data accesses 43us
// - Eight-bit mode moves a byte per strobe
// - Step direction high increments, low decrements
// - Busy flag reads high while executing
// - Four-bit uses upper lines, high nibble first
package lcd_instr_pkg;
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned SHORT_NS      = 39_000;
  localparam int unsigned DATA_NS       = 43_000;
  localparam int unsigned LONG_NS       = 1_530_000;
  localparam int unsigned SHORT_CYCLES  = SHORT_NS / 5;
  localparam int unsigned DATA_CYCLES   = DATA_NS / 5;
  localparam int unsigned LONG_CYCLES   = LONG_NS / 5;
  localparam logic [6:0]  CHAR_DEPTH    = 7'h50;
  localparam logic [6:0]  LINE2_BASE    = 7'h40;
  localparam logic [6:0]  LINE1_LAST    = 7'h27;
  localparam logic [6:0]  LINE2_LAST    = 7'h67;
  localparam logic [6:0]  ONE_LINE_LAST = 7'h4f;
  localparam logic [6:0]  LEN_ONE       = 7'h50;
  localparam logic [6:0]  LEN_TWO       = 7'h28;
  localparam logic [7:0]  SPACE_CODE    = 8'h20;
  localparam logic        RST_BUS_8BIT  = 1'b1;
  localparam logic        RST_STEP_UP   = 1'b1;
endpackage

// ---- rtl/lcd_busy_timer.sv ----
`timescale 1ns/1ps
// Busy timer: holds busy for a loaded number of core cycles.
// Assumes load is a one-cycle pulse from the decoder.
module lcd_busy_timer #(
  parameter int unsigned W = 20
) (
  input  wire logic         core_clk_in,
  input  wire logic         nrst_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] count_in,
  output logic              busy_out
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } tmr_s;
  tmr_s st;
  tmr_s next_st;

  always_comb
  begin
    next_st = st;
    if (load_in)
      next_st.cnt = count_in;
    else if (st.cnt != '0)
      next_st.cnt = st.cnt - 1'b1;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!nrst_in)
      st <= '0;
    else
      st <= next_st;
  end

  assign busy_out = (st.cnt != '0);
endmodule

// ---- rtl/char_lcd_instruction_decoder.sv ----
`timescale 1ns/1ps
// Instruction decoder of the character display controller.
// Assumes the host obeys busy and strobe spacing; bus pins are asynchronous.
module char_lcd_instruction_decoder #(
  parameter int unsigned LONG_CNT = lcd_instr_pkg::LONG_CYCLES
) (
  input  wire logic       core_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       register_select_in,
  input  wire logic       read_not_write_in,
  input  wire logic       strobe_in,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe_out,
  output logic            internal_busy_flag_out,
  output logic      [6:0] ram_pointer_out,
  output logic            bus_width_select_out,
  output logic            line_count_select_out,
  output logic            font_height_select_out,
  output logic            pointer_step_direction_out,
  output logic            auto_display_shift_out,
  output logic            display_on_out,
  output logic            cursor_on_out,
  output logic            blink_on_out,
  output logic      [6:0] display_offset_out
);
  localparam int unsigned TW = 20;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CLEAR = 2'b01
  } phase_e;

  typedef struct packed {
    logic [1:0] rs_s;
    logic [1:0] rw_s;
    logic [1:0] e_s;
    logic [7:0] d_s0;
    logic [7:0] d_s1;
    logic       e_prev;
    logic       nib_second;
    logic [3:0] nib_hi;
    logic [6:0] ptr;
    logic       sel_char;
    logic [6:0] offset;
    logic [7:0] out_reg;
    logic [7:0] dout;
    logic       oe;
    logic       dl;
    logic       nl;
    logic       fh;
    logic       step_up;
    logic       sh;
    logic       d_on;
    logic       c_on;
    logic       b_on;
    phase_e     phase;
    logic [6:0] clr_idx;
  } dec_s;

  dec_s st;
  dec_s next_st;
  logic [7:0] char_ram [0:79];
  logic [7:0] glyph_ram [0:63];
  logic          tmr_load;
  logic [TW-1:0] tmr_count;
  logic          busy;
  logic          ram_we;
  logic          ram_we_char;
  logic [6:0]    ram_waddr;
  logic [7:0]    ram_wdata;

  // Pointer step honouring line layout and direction
  function automatic logic [6:0] step_ptr(input logic [6:0] p,
                                          input logic up,
                                          input logic two,
                                          input logic chr);
    logic [6:0] r;
    r = up ? p + 7'd1 : p - 7'd1;
    if (!chr)
      r = {1'b0, r[5:0]};
    else if (!two)
    begin
      if (up && p == lcd_instr_pkg::ONE_LINE_LAST)
        r = 7'h00;
      else if (!up && p == 7'h00)
        r = lcd_instr_pkg::ONE_LINE_LAST;
    end
    else
    begin
      if (up && p == lcd_instr_pkg::LINE1_LAST)
        r = lcd_instr_pkg::LINE2_BASE;
      else if (up && p == lcd_instr_pkg::LINE2_LAST)
        r = 7'h00;
      else if (!up && p == lcd_instr_pkg::LINE2_BASE)
        r = lcd_instr_pkg::LINE1_LAST;
      else if (!up && p == 7'h00)
        r = lcd_instr_pkg::LINE2_LAST;
    end
    return r;
  endfunction

  // Map a pointer onto the flat 80-entry character store
  function automatic logic [6:0] char_idx(input logic [6:0] p);
    logic [6:0] r;
    r = p[6] ? p - 7'h18 : p;
    if (r >= lcd_instr_pkg::CHAR_DEPTH)
      r = 7'h00;
    return r;
  endfunction

  function automatic logic [7:0] ram_rd(input logic chr,
                                        input logic [6:0] p);
    logic [7:0] r;
    r = chr ? char_ram[char_idx(p)] : glyph_ram[p[5:0]];
    return r;
  endfunction

  lcd_busy_timer #(.W(TW)) u_busy (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .load_in     (tmr_load),
    .count_in    (tmr_count),
    .busy_out    (busy)
  );

  always_comb
  begin
    logic [7:0] byte_v;
    logic       act;
    logic       fall;
    logic [6:0] len;
    byte_v = 8'h00;
    act = 1'b0;
    next_st = st;
    tmr_load = 1'b0;
    tmr_count = '0;
    ram_we = 1'b0;
    ram_we_char = 1'b0;
    ram_waddr = 7'h00;
    ram_wdata = 8'h00;
    next_st.rs_s = {st.rs_s[0], register_select_in};
    next_st.rw_s = {st.rw_s[0], read_not_write_in};
    next_st.e_s  = {st.e_s[0], strobe_in};
    next_st.d_s0 = data_in;
    next_st.d_s1 = st.d_s0;
    next_st.e_prev = st.e_s[1];
    fall = st.e_prev && !st.e_s[1];
    len = st.nl ? lcd_instr_pkg::LEN_TWO : lcd_instr_pkg::LEN_ONE;
    // Read data is presented while strobe is high; 4-bit reads give
    // the high nibble first on the upper lines
    next_st.oe = st.e_s[1] && st.rw_s[1];
    if (st.rs_s[1])
      byte_v = st.out_reg;
    else
      byte_v = {busy, st.ptr};
    if (st.dl || !st.nib_second)
      next_st.dout = byte_v;
    else
      next_st.dout = {byte_v[3:0], 4'h0};
    if (st.phase == ST_CLEAR)
    begin
      ram_we = 1'b1;
      ram_we_char = 1'b1;
      ram_waddr = st.clr_idx;
      ram_wdata = lcd_instr_pkg::SPACE_CODE;
      next_st.clr_idx = st.clr_idx + 7'd1;
      if (st.clr_idx == lcd_instr_pkg::CHAR_DEPTH - 7'd1)
        next_st.phase = ST_IDLE;
    end
    if (fall)
    begin
      if (st.dl)
      begin
        byte_v = st.d_s1;
        act = 1'b1;
      end
      else if (!st.nib_second)
      begin
        next_st.nib_hi = st.d_s1[7:4];
        next_st.nib_second = 1'b1;
      end
      else
      begin
        byte_v = {st.nib_hi, st.d_s1[7:4]};
        next_st.nib_second = 1'b0;
        act = 1'b1;
      end
    end
    if (act && !st.rs_s[1] && !st.rw_s[1])
    begin
      tmr_load = 1'b1;
      tmr_count = TW'(lcd_instr_pkg::SHORT_CYCLES);
      if (byte_v[7])
      begin
        next_st.ptr = byte_v[6:0];
        next_st.sel_char = 1'b1;
        next_st.out_reg = ram_rd(1'b1, byte_v[6:0]);
      end
      else if (byte_v[6])
      begin
        next_st.ptr = {1'b0, byte_v[5:0]};
        next_st.sel_char = 1'b0;
        next_st.out_reg = ram_rd(1'b0, {1'b0, byte_v[5:0]});
      end
      else if (byte_v[5])
      begin
        next_st.dl = byte_v[4];
        next_st.nl = byte_v[3];
        next_st.fh = byte_v[2];
      end
      else if (byte_v[4])
      begin
        if (!byte_v[3])
        begin
          next_st.ptr = step_ptr(st.ptr, byte_v[2], st.nl,
                                 st.sel_char);
          if (st.sel_char)
            next_st.out_reg = ram_rd(1'b1, next_st.ptr);
        end
        else if (byte_v[2])
          next_st.offset = (st.offset == len - 7'd1) ? 7'h00
                           : st.offset + 7'd1;
        else
          next_st.offset = (st.offset == 7'h00) ? len - 7'd1
                           : st.offset - 7'd1;
      end
      else if (byte_v[3])
      begin
        next_st.d_on = byte_v[2];
        next_st.c_on = byte_v[1];
        next_st.b_on = byte_v[0];
      end
      else if (byte_v[2])
      begin
        next_st.step_up = byte_v[1];
        next_st.sh = byte_v[0];
      end
      else if (byte_v[1])
      begin
        next_st.ptr = 7'h00;
        next_st.offset = 7'h00;
        tmr_count = TW'(LONG_CNT);
      end
      else if (byte_v[0])
      begin
        next_st.ptr = 7'h00;
        next_st.offset = 7'h00;
        next_st.step_up = 1'b1;
        next_st.sel_char = 1'b1;
        next_st.phase = ST_CLEAR;
        next_st.clr_idx = 7'h00;
        tmr_count = TW'(LONG_CNT);
      end
      else
        tmr_load = 1'b0;
    end
    else if (act && st.rs_s[1])
    begin
      tmr_load = 1'b1;
      tmr_count = TW'(lcd_instr_pkg::DATA_CYCLES);
      next_st.ptr = step_ptr(st.ptr, st.step_up, st.nl, st.sel_char);
      if (!st.rw_s[1])
      begin
        ram_we = 1'b1;
        ram_we_char = st.sel_char;
        ram_waddr = st.ptr;
        ram_wdata = byte_v;
        if (st.sh && st.sel_char)
          next_st.offset = st.step_up
            ? ((st.offset == len - 7'd1) ? 7'h00 : st.offset + 7'd1)
            : ((st.offset == 7'h00) ? len - 7'd1 : st.offset - 7'd1);
      end
      else
        next_st.out_reg = ram_rd(st.sel_char, next_st.ptr);
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (ram_we && ram_we_char)
      char_ram[(st.phase == ST_CLEAR) ? ram_waddr
               : char_idx(ram_waddr)] <= ram_wdata;
    else if (ram_we)
      glyph_ram[ram_waddr[5:0]] <= ram_wdata;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      st <= '0;
      st.dl <= lcd_instr_pkg::RST_BUS_8BIT;
      st.step_up <= lcd_instr_pkg::RST_STEP_UP;
      st.sel_char <= 1'b1;
      st.phase <= ST_IDLE;
    end
    else
      st <= next_st;
  end

  assign data_out = st.dout;
  assign data_oe_out = st.oe;
  assign internal_busy_flag_out = busy;
  assign ram_pointer_out = st.ptr;
  assign bus_width_select_out = st.dl;
  assign line_count_select_out = st.nl;
  assign font_height_select_out = st.fh;
  assign pointer_step_direction_out = st.step_up;
  assign auto_display_shift_out = st.sh;
  assign display_on_out = st.d_on;
  assign cursor_on_out = st.c_on;
  assign blink_on_out = st.b_on;
  assign display_offset_out = st.offset;
endmodule

// ---- tb/lcd_decoder_monitor.sv ----
// Checker for the character display instruction decoder.
// Assumes a host that waits for busy low before each instruction.
`timescale 1ns/1ps
module lcd_decoder_monitor #(
  parameter int unsigned LONG_CNT = 50
) (
  input wire logic       core_clk_in,
  input wire logic       nrst_in,
  input wire logic       register_select_in,
  input wire logic       read_not_write_in,
  input wire logic       strobe_in,
  input wire logic [7:0] data_in,
  input wire logic       internal_busy_flag_out,
  input wire logic [6:0] ram_pointer_out,
  input wire logic       bus_width_select_out,
  input wire logic       line_count_select_out,
  input wire logic       font_height_select_out,
  input wire logic [6:0] display_offset_out
);
  logic [19:0] busy_len;
  logic [7:0]  code;
  logic [6:0]  ptr_at;
  logic        half;
  wire         stat = !register_select_in && read_not_write_in;
  wire         c8 = !register_select_in && !read_not_write_in &&
                    bus_width_select_out;
  // Nibble parity counts every strobe in four-bit mode, reads too
  always_ff @(posedge core_clk_in)
  begin
    busy_len <= internal_busy_flag_out ? busy_len + 20'h1 : 20'h0;
    if ($fell(strobe_in))
    begin
      code <= data_in;
      ptr_at <= ram_pointer_out;
    end
    if (!nrst_in)
      half <= 1'b0;
    else if ($fell(strobe_in) && !bus_width_select_out)
      half <= !half;
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_take;
    $fell(strobe_in) && !internal_busy_flag_out;
  endsequence
  sequence s_quiet;
    ##1 !internal_busy_flag_out [*8];
  endsequence
  sequence s_busy;
    ##[2:8] internal_busy_flag_out;
  endsequence
  AST_BUSY_LEN: assert property (
    $fell(internal_busy_flag_out) |-> busy_len == 20'd7800 ||
    busy_len == 20'd8600 || busy_len == LONG_CNT)
    else $error("busy length wrong");
  AST_STATUS_FREE: assert property (s_take ##0 stat |-> s_quiet)
    else $error("status read made busy");
  AST_BYTE_BUSY: assert property (
    s_take ##0 (bus_width_select_out && !stat &&
    (register_select_in || data_in != 8'h00)) |-> s_busy)
    else $error("byte did not raise busy");
  AST_NIBBLE_HOLD: assert property (
    s_take ##0 (!bus_width_select_out && !half) |-> s_quiet)
    else $error("first nibble raised busy");
  AST_NIBBLE_BUSY: assert property (
    s_take ##0 (!bus_width_select_out && half && !stat) |-> s_busy)
    else $error("second nibble left busy low");
  AST_VIEW_SHIFT: assert property (
    s_take ##0 (c8 && data_in[7:3] == 5'b00011) |->
    ##1 $stable(ram_pointer_out) [*8])
    else $error("display shift moved pointer");
  AST_CURSOR_LEFT: assert property (
    s_take ##0 (c8 && data_in[7:2] == 6'b000100 &&
    ram_pointer_out != 7'h00 && ram_pointer_out != 7'h40) |->
    ##[2:8] ram_pointer_out == ptr_at - 7'h1)
    else $error("cursor left did not decrement");
  AST_HOME: assert property (
    s_take ##0 (c8 && data_in[7:1] == 7'h01) |->
    ##[2:8] ram_pointer_out == 7'h00 && display_offset_out == 7'h00)
    else $error("home did not zero pointer and offset");
  AST_CLEAR: assert property (
    s_take ##0 (c8 && data_in == 8'h01) |-> ##[2:8] ram_pointer_out == 7'h00)
    else $error("clear did not zero pointer");
  AST_FUNC: assert property (
    s_take ##0 (c8 && data_in[7:5] == 3'b001) |-> ##[2:8]
    {bus_width_select_out, line_count_select_out,
    font_height_select_out} == code[4:2])
    else $error("function set fields wrong");
  AST_CHAR_ADDR: assert property (
    s_take ##0 (c8 && data_in[7]) |-> ##[2:8] ram_pointer_out == code[6:0])
    else $error("character address not loaded");
endmodule
bind char_lcd_instruction_decoder lcd_decoder_monitor #(
  .LONG_CNT(LONG_CNT)
) mon_u (.*);

// ---- tb/lcd_host_model.sv ----
// Host processor model driving the display decoder's parallel bus.
// Assumes four-bit mode follows the decoder's bus width output.
`timescale 1ns/1ps
module lcd_host_model (
  input  wire logic       core_clk_in,
  input  wire logic       busy_in,
  input  wire logic       four_bit_in,
  input  wire logic [7:0] rd_in,
  output logic            rs_out,
  output logic            rw_out,
  output logic            strobe_out,
  output logic      [7:0] wd_out,
  output logic            done_out,
  output logic            hang_out,
  output logic      [7:0] result_out
);
  initial
  begin
    {rs_out, rw_out, strobe_out, done_out, hang_out} = 5'h00;
    wd_out = 8'h00;
    result_out = 8'h00;
  end
  task automatic beat(input logic rs, rw, input logic [7:0] b,
                      output logic [7:0] r);
    @(posedge core_clk_in);
    rs_out <= rs;
    rw_out <= rw;
    wd_out <= b;
    repeat (3) @(posedge core_clk_in);
    strobe_out <= 1'b1;
    repeat (6) @(posedge core_clk_in);
    r = rd_in;
    strobe_out <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    // Released lines show no stale copy of the last byte
    wd_out <= ~b;
    repeat (4) @(posedge core_clk_in);
  endtask
  task automatic xfer(input logic rs, rw, input logic [7:0] b);
    logic [7:0] h;
    logic [7:0] l;
    int         n;
    n = 0;
    if (rs || !rw)
    begin
      while (busy_in === 1'b1 && n < 20000)
      begin
        @(posedge core_clk_in);
        n++;
      end
      if (n == 20000)
        hang_out <= 1'b1;
      repeat (371) @(posedge core_clk_in);
    end
    if (four_bit_in)
    begin
      beat(rs, rw, {b[7:4], ~b[7:4]}, h);
      beat(rs, rw, {b[3:0], ~b[3:0]}, l);
      result_out <= {h[7:4], l[7:4]};
    end
    else
    begin
      beat(rs, rw, b, h);
      result_out <= h;
    end
    done_out <= rw;
    @(posedge core_clk_in);
    done_out <= 1'b0;
  endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the instruction decoder with a host model.
// Assumes the package busy figures; the long count is shortened to 50.
`timescale 1ns/1ps
module tb_top;
  logic       core_clk_in = 1'b0;
  logic       nrst_in = 1'b0;
  logic       rs, rw, stb, done, hang, busy, bw, nl, fh, step;
  logic       d_on, c_on, b_on;
  logic [7:0] wd, dout, res, rnd;
  logic [6:0] ptr, ofs;
  logic [7:0] q[$];
  int         miscompares = 0;
  int         compares = 0;
  int         seed = 93;
  always #2.5 core_clk_in = ~core_clk_in;
  char_lcd_instruction_decoder #(.LONG_CNT(50)) dut_u (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .register_select_in(rs), .read_not_write_in(rw), .strobe_in(stb),
    .data_in(wd), .data_out(dout), .data_oe_out(),
    .internal_busy_flag_out(busy), .ram_pointer_out(ptr),
    .bus_width_select_out(bw), .line_count_select_out(nl),
    .font_height_select_out(fh), .pointer_step_direction_out(step),
    .auto_display_shift_out(), .display_on_out(d_on),
    .cursor_on_out(c_on), .blink_on_out(b_on),
    .display_offset_out(ofs));
  lcd_host_model host_u (
    .core_clk_in(core_clk_in), .busy_in(busy), .four_bit_in(!bw),
    .rd_in(dout), .rs_out(rs), .rw_out(rw), .strobe_out(stb),
    .wd_out(wd), .done_out(done), .hang_out(hang), .result_out(res));
  task automatic chk(input string n, input logic [7:0] s, e);
    compares++;
    if (s !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic rd(input logic r, input logic [7:0] e);
    q.push_back(e);
    host_u.xfer(r, 1'b1, 8'h00);
  endtask
  always @(posedge core_clk_in)
    if (done === 1'b1)
      chk("read", res, q.pop_front());
  always @(posedge core_clk_in)
    if (hang === 1'b1)
    begin
      miscompares++;
      stop_test();
    end
  initial
  begin
    repeat (5) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    rd(1'b0, 8'h00);
    host_u.xfer(1'b0, 1'b0, 8'h01);
    rd(1'b0, 8'h80);
    chk("step", {7'h00, step}, 8'h01);
    rnd = $random(seed);
    host_u.xfer(1'b1, 1'b0, rnd);
    rd(1'b0, 8'h81);
    $display("test clear_write done");
    host_u.xfer(1'b0, 1'b0, 8'h80);
    rd(1'b1, rnd);
    host_u.xfer(1'b0, 1'b0, 8'h10);
    rd(1'b0, 8'h80);
    rd(1'b1, rnd);
    rd(1'b1, 8'h20);
    $display("test read_shift done");
    host_u.xfer(1'b0, 1'b0, 8'h1c);
    rd(1'b0, 8'h82);
    chk("offset", {1'b0, ofs}, 8'h01);
    host_u.xfer(1'b0, 1'b0, 8'h02);
    rd(1'b0, 8'h80);
    chk("offset", {1'b0, ofs}, 8'h00);
    host_u.xfer(1'b0, 1'b0, 8'h2c);
    chk("mode", {5'h00, bw, nl, fh}, 8'h03);
    $display("test home_func done");
    host_u.xfer(1'b0, 1'b0, 8'ha7);
    rd(1'b0, 8'ha7);
    host_u.xfer(1'b1, 1'b0, 8'h55);
    rd(1'b0, 8'hc0);
    host_u.xfer(1'b0, 1'b0, 8'h0f);
    chk("display", {5'h00, d_on, c_on, b_on}, 8'h07);
    $display("test nibble done");
    stop_test();
  end
endmodule
